// File: core/pcc_map.svh
`ifndef PCC_MAP_SVH
`define PCC_MAP_SVH
// register indices; byte address is four times the index
`define PCC_IDX_CLOCK_OUT_PIN_CONTROL_STATUS 16'h7010
`define PCC_IDX_PLL_STATUS 16'h7011
`define PCC_IDX_HSPRE 16'h701a
`define PCC_IDX_LSPRE 16'h701b
`define PCC_IDX_GATE0 16'h701c
`define PCC_IDX_GATE1 16'h701d
`define PCC_IDX_LPM 16'h701e
`define PCC_IDX_PLL_CONTROL 16'h7021
`define PCC_IDX_SYSTEM_CONTROL_STATUS 16'h7022
`define PCC_IDX_WDCNT 16'h7023
`define PCC_IDX_WATCHDOG_KEY 16'h7025
`define PCC_IDX_WATCHDOG_CONTROL 16'h7029
`define PCC_IDX_PROT 16'h7030
// field positions
`define PCC_STS_LOCK 0
`define PCC_STS_DIVSEL 1
`define PCC_STS_OFF 3
`define PCC_CLOCK_OUT_PIN_CONTROL_STATUS_EXTSEL 0
`define PCC_CLOCK_OUT_PIN_CONTROL_STATUS_CRYST 1
`define PCC_CLOCK_OUT_PIN_CONTROL_STATUS_EXTST 2
`define PCC_PROT_EN 0
// ratio codes, counts, response codes and the empty slot code
`define PCC_RATIO_BYP 4'h0
`define PCC_RATIO_MAX 4'ha
`define PCC_LOCK_OSC 131072
`define PCC_OSC_DIV 25
`define PCC_RESP_OKAY 2'h0
`define PCC_RESP_SLVERR 2'h2
`define PCC_SLOT_NONE 3'h7
`endif

// File: core/pcc_pkg.sv
package pcc_pkg;
	typedef enum logic [1:0] {PCC_OFF, PCC_BYPASS, PCC_LOCKING, PCC_LOCKED}
		pcc_mode_e;
endpackage

// File: core/pcc_pll_clock_control.sv
// The AXI4-Lite register port was decided locally.
`include "pcc_map.svh"
module pcc_pll_clock_control
	import pcc_pkg::*;
#(
	parameter int LOCK_OSC = `PCC_LOCK_OSC,
	parameter int OSC_DIV = `PCC_OSC_DIV
)
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [17:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [17:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic crystalInPin,
	input wire logic extClockPin,
	output logic crystalOutPin,
	output logic cpuClockEn,
	output logic systemClockOut,
	output logic pllPowered,
	output logic pllLocked
);

	localparam int LCW = $clog2(LOCK_OSC + 1);
	localparam logic [15:0] WRAP = 16'(2 * OSC_DIV);

	function automatic logic [2:0] plainSlot(input logic [15:0] idx);
		unique case (idx)
			`PCC_IDX_HSPRE: plainSlot = 3'h0;
			`PCC_IDX_LSPRE: plainSlot = 3'h1;
			`PCC_IDX_GATE0: plainSlot = 3'h2;
			`PCC_IDX_GATE1: plainSlot = 3'h3;
			`PCC_IDX_LPM: plainSlot = 3'h4;
			`PCC_IDX_WATCHDOG_CONTROL: plainSlot = 3'h5;
			default: plainSlot = `PCC_SLOT_NONE;
		endcase
	endfunction

	function automatic logic mapped(input logic [15:0] idx);
		mapped = plainSlot(idx) != `PCC_SLOT_NONE || idx == `PCC_IDX_CLOCK_OUT_PIN_CONTROL_STATUS
			|| idx == `PCC_IDX_PLL_STATUS || idx == `PCC_IDX_PLL_CONTROL
			|| idx == `PCC_IDX_SYSTEM_CONTROL_STATUS || idx == `PCC_IDX_WDCNT
			|| idx == `PCC_IDX_WATCHDOG_KEY || idx == `PCC_IDX_PROT;
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] s);
		merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// bus slave

	logic [15:0] awIdxQ;
	logic [31:0] wDataQ;
	logic [3:0] wStrbQ;
	logic wrFire;
	logic wrAllowed;
	logic [15:0] wrVal;
	logic protQ;

	assign wrFire = !awready && !wready && !bvalid;
	assign wrAllowed = protQ || awIdxQ == `PCC_IDX_PROT;

	always_ff @(posedge clock or negedge reset_n)
		if (!reset_n)
		begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= `PCC_RESP_OKAY;
			awIdxQ <= 16'h0000;
			wDataQ <= 32'h0000_0000;
			wStrbQ <= 4'h0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				awready <= 1'b0;
				awIdxQ <= awaddr[17:2];
			end
			if (wvalid && wready)
			begin
				wready <= 1'b0;
				wDataQ <= wdata;
				wStrbQ <= wstrb;
			end
			if (wrFire)
			begin
				bvalid <= 1'b1;
				bresp <= mapped(awIdxQ) ? `PCC_RESP_OKAY : `PCC_RESP_SLVERR;
			end
			if (bvalid && bready)
			begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end

	logic [15:0] regWord;
	logic [15:0] plainQ [0:5];
	logic [3:0] ratioQ;
	logic divSelQ;
	logic offQ;
	logic extSelQ;
	logic pinQ;
	pcc_mode_e modeQ;

	always_comb
	begin
		unique case (araddr[17:2])
			`PCC_IDX_CLOCK_OUT_PIN_CONTROL_STATUS: regWord = 16'(
				{extClockPin, crystalInPin, extSelQ} << `PCC_CLOCK_OUT_PIN_CONTROL_STATUS_EXTSEL);
			`PCC_IDX_PLL_STATUS: regWord = 16'((16'(offQ) << `PCC_STS_OFF)
				| (16'(divSelQ) << `PCC_STS_DIVSEL)
				| (16'(modeQ == PCC_LOCKED) << `PCC_STS_LOCK));
			`PCC_IDX_PLL_CONTROL: regWord = {12'h000, ratioQ};
			`PCC_IDX_PROT: regWord = 16'(protQ) << `PCC_PROT_EN;
			default: regWord = plainSlot(araddr[17:2]) == `PCC_SLOT_NONE
				? 16'h0000 : plainQ[plainSlot(araddr[17:2])];
		endcase
	end

	always_ff @(posedge clock or negedge reset_n)
		if (!reset_n)
		begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `PCC_RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= {16'h0000, regWord};
			rresp <= mapped(araddr[17:2]) ? `PCC_RESP_OKAY : `PCC_RESP_SLVERR;
		end
		else if (rvalid && rready)
		begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end

	////////////////////////////////////////////////////////////////////////
	// registers

	logic ctlWrite;
	logic stsWrite;
	assign wrVal = merge(16'h0000, wDataQ, wStrbQ);
	assign ctlWrite = wrFire && wrAllowed && awIdxQ == `PCC_IDX_PLL_CONTROL;
	assign stsWrite = wrFire && wrAllowed && awIdxQ == `PCC_IDX_PLL_STATUS;

	always_ff @(posedge clock or negedge reset_n)
		if (!reset_n)
			protQ <= 1'b0;
		else if (wrFire && awIdxQ == `PCC_IDX_PROT)
			protQ <= wrVal[`PCC_PROT_EN];

	always_ff @(posedge clock or negedge reset_n)
		if (!reset_n)
			ratioQ <= `PCC_RATIO_BYP;
		else if (ctlWrite)
			ratioQ <= wStrbQ[0] ? wDataQ[3:0] : ratioQ;

	always_ff @(posedge clock or negedge reset_n)
		if (!reset_n)
		begin
			divSelQ <= 1'b0;
			offQ <= 1'b0;
		end
		else if (stsWrite)
		begin
			divSelQ <= wrVal[`PCC_STS_DIVSEL];
			offQ <= wrVal[`PCC_STS_OFF];
		end

	always_ff @(posedge clock or negedge reset_n)
		if (!reset_n)
			extSelQ <= 1'b0;
		else if (wrFire && wrAllowed && awIdxQ == `PCC_IDX_CLOCK_OUT_PIN_CONTROL_STATUS)
			extSelQ <= wrVal[`PCC_CLOCK_OUT_PIN_CONTROL_STATUS_EXTSEL];

	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++)
		begin : g_plain
			always_ff @(posedge clock or negedge reset_n)
				if (!reset_n)
					plainQ[gi] <= 16'h0000;
				else if (wrFire && wrAllowed && plainSlot(awIdxQ) == 3'(gi))
					plainQ[gi] <= merge(plainQ[gi], wDataQ, wStrbQ);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// oscillator and lock sequencing

	logic oscTick;
	logic [LCW-1:0] lockCntQ;
	logic lockDone;
	logic ratioOk;

	assign oscTick = (extSelQ ? extClockPin : crystalInPin) && !pinQ;
	assign ratioOk = ratioQ != `PCC_RATIO_BYP && ratioQ <= `PCC_RATIO_MAX;
	assign lockDone = oscTick && lockCntQ == LCW'(LOCK_OSC - 1);

	always_ff @(posedge clock or negedge reset_n)
		if (!reset_n)
		begin
			pinQ <= 1'b0;
			crystalOutPin <= 1'b0;
		end
		else
		begin
			pinQ <= extSelQ ? extClockPin : crystalInPin;
			crystalOutPin <= !extSelQ && !crystalInPin;
		end

	always_ff @(posedge clock or negedge reset_n)
		if (!reset_n)
			lockCntQ <= '0;
		else if (ctlWrite || modeQ != PCC_LOCKING)
			lockCntQ <= '0;
		else if (oscTick && !lockDone)
			lockCntQ <= lockCntQ + LCW'(1);

	always_ff @(posedge clock or negedge reset_n)
		if (!reset_n)
			modeQ <= PCC_BYPASS;
		else if (stsWrite && wrVal[`PCC_STS_OFF])
			modeQ <= PCC_OFF;
		else if (ctlWrite || (stsWrite && modeQ == PCC_OFF))
			modeQ <= PCC_LOCKING;
		else if (modeQ == PCC_LOCKING && (lockDone || !ratioOk))
			modeQ <= ratioOk ? PCC_LOCKED : PCC_BYPASS;

	////////////////////////////////////////////////////////////////////////
	// cpu clock generation

	logic [15:0] accQ;
	logic [15:0] accSum;
	logic [3:0] incQ;
	logic [3:0] incTarget;

	assign incTarget = (modeQ == PCC_LOCKED && ratioOk) ? ratioQ
		: (divSelQ ? 4'h2 : 4'h1);
	assign accSum = accQ + 16'(incQ);

	always_ff @(posedge clock or negedge reset_n)
		if (!reset_n)
		begin
			accQ <= 16'h0000;
			incQ <= 4'h1;
			cpuClockEn <= 1'b0;
			systemClockOut <= 1'b0;
		end
		else
		begin
			cpuClockEn <= accSum >= WRAP;
			systemClockOut <= accSum >= WRAP;
			if (accSum >= WRAP)
			begin
				accQ <= accSum - WRAP;
				incQ <= incTarget;
			end
			else
				accQ <= accSum;
		end

	always_ff @(posedge clock or negedge reset_n)
		if (!reset_n)
		begin
			pllPowered <= 1'b1;
			pllLocked <= 1'b0;
		end
		else
		begin
			pllPowered <= modeQ != PCC_OFF;
			pllLocked <= modeQ == PCC_LOCKED;
		end

	////////////////////////////////////////////////////////////////////////
	// assertions

	logic pulse;
	assign pulse = accSum >= WRAP;

	property p_ratioStore;
		@(posedge clock) disable iff (!reset_n)
		ctlWrite && wStrbQ[0] |=> ratioQ == $past(wDataQ[3:0]);
	endproperty
	a_ratioStore: assert property (p_ratioStore)
		else $error("ratio field not stored");

	property p_mult;
		@(posedge clock) disable iff (!reset_n)
		pulse && modeQ == PCC_LOCKED && ratioOk |=> incQ == $past(ratioQ);
	endproperty
	a_mult: assert property (p_mult)
		else $error("multiplied rate not applied");

	property p_bypassRate;
		@(posedge clock) disable iff (!reset_n)
		pulse && modeQ != PCC_LOCKED
			|=> incQ == ($past(divSelQ) ? 4'h2 : 4'h1);
	endproperty
	a_bypassRate: assert property (p_bypassRate)
		else $error("bypass rate wrong");

	property p_writeBypass;
		@(posedge clock) disable iff (!reset_n)
		ctlWrite |=> modeQ != PCC_LOCKED ##1 !pllLocked;
	endproperty
	a_writeBypass: assert property (p_writeBypass)
		else $error("locked right after control write");

	property p_lockTime;
		@(posedge clock) disable iff (!reset_n)
		$rose(modeQ == PCC_LOCKED) |-> $past(lockCntQ) == LCW'(LOCK_OSC - 1);
	endproperty
	a_lockTime: assert property (p_lockTime)
		else $error("lock before full count");

	sequence s_offWrite;
		stsWrite && wrVal[`PCC_STS_OFF];
	endsequence
	sequence s_offSettle;
		modeQ == PCC_OFF ##1 !pllPowered;
	endsequence
	property p_powerOff;
		@(posedge clock) disable iff (!reset_n)
		s_offWrite |=> s_offSettle;
	endproperty
	a_powerOff: assert property (p_powerOff)
		else $error("power off not taken");

	property p_bypassPowered;
		@(posedge clock) disable iff (!reset_n)
		modeQ == PCC_BYPASS |=> pllPowered;
	endproperty
	a_bypassPowered: assert property (p_bypassPowered)
		else $error("pll unpowered in bypass");

	property p_sysOut;
		@(posedge clock) disable iff (!reset_n)
		systemClockOut == cpuClockEn;
	endproperty
	a_sysOut: assert property (p_sysOut)
		else $error("system clock out differs");

	property p_protect;
		@(posedge clock) disable iff (!reset_n)
		wrFire && !protQ && awIdxQ == `PCC_IDX_PLL_CONTROL
			|=> $stable(ratioQ)
			&& !(modeQ == PCC_LOCKING && $past(modeQ) != PCC_LOCKING);
	endproperty
	a_protect: assert property (p_protect)
		else $error("protected write taken");

	property p_noRunt;
		@(posedge clock) disable iff (!reset_n)
		cpuClockEn |=> !cpuClockEn;
	endproperty
	a_noRunt: assert property (p_noRunt)
		else $error("clock pulses back to back");

endmodule

// File: dv/pcc_osc_model.sv
module pcc_osc_model
#(
	parameter int PERIOD = 25
)
(
	input wire logic clock,
	input wire logic useExt,
	output logic crystalInPin,
	output logic extClockPin
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	logic osc = 1'b0;
	always @(posedge clock)
	begin
		cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
		if (cnt == 0 || cnt == PERIOD / 2)
			osc <= ~osc;
	end
	assign crystalInPin = useExt ? 1'b0 : osc;
	assign extClockPin = useExt ? osc : 1'b0;
endmodule

// File: dv/testbench.sv
`include "pcc_map.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LOCK = 16;
	localparam int ODIV = 25;
	logic clock, reset_n, awvalid, wvalid, bready, arvalid, rready;
	logic useExt, awready, wready, bvalid, arready, rvalid;
	logic crystalInPin, extClockPin, crystalOutPin, cpuClockEn;
	logic systemClockOut, pllPowered, pllLocked;
	logic [17:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [33:0] rdQ[$];
	logic [1:0] wrQ[$];
	int num_errors = 0;
	int n_tests = 0;
	int seed = 29248;
	int n, t;

	pcc_pll_clock_control #(.LOCK_OSC(LOCK), .OSC_DIV(ODIV))
	u_pcc_pll_clock_control (.clock, .reset_n, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
		.bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .crystalInPin, .extClockPin, .crystalOutPin,
		.cpuClockEn, .systemClockOut, .pllPowered, .pllLocked);
	pcc_osc_model #(.PERIOD(ODIV)) u_pcc_osc_model (.clock, .useExt,
		.crystalInPin, .extClockPin);

	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	task summarize;
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task fail(input string m);
		num_errors++;
		$display("mismatch at %0t: %s", $time, m);
	endtask

	task chk(input logic [33:0] got, input logic [33:0] exp, string m);
		n_tests++;
		if (got !== exp)
			fail(m);
	endtask

	////////////////////////////////////////////////////////////////
	// bus master and clock rate check
	task wr(input logic [15:0] idx, input logic [31:0] v,
		input logic [1:0] er = `PCC_RESP_OKAY);
		wrQ.push_back(er);
		awaddr <= {idx, 2'h0};
		wdata <= v;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		t = 0;
		do
		begin
			@(posedge clock);
			t++;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1 && t < 1000);
		if (t >= 1000)
		begin
			fail("write hang");
			summarize;
		end
	endtask

	task rd(input logic [15:0] idx, input logic [31:0] v,
		input logic [1:0] er = `PCC_RESP_OKAY);
		rdQ.push_back({er, v});
		araddr <= {idx, 2'h0};
		arvalid <= 1'b1;
		t = 0;
		do
		begin
			@(posedge clock);
			t++;
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1 && t < 1000);
		if (t >= 1000)
		begin
			fail("read hang");
			summarize;
		end
	endtask

	task rate(input int k);
		int c;
		logic pin;
		c = 0;
		repeat (50) @(posedge clock);
		pin = crystalInPin;
		repeat (500)
		begin
			@(posedge clock);
			if (cpuClockEn === 1'b1)
				c++;
			n_tests++;
			if (crystalOutPin !== (!useExt && !pin))
				fail("crystal out");
			pin = crystalInPin;
		end
		n_tests++;
		if (c < k * 10 - 1 || c > k * 10 + 1)
			fail("clock rate");
	endtask

	////////////////////////////////////////////////////////////////
	// result watcher
	always @(posedge clock)
	begin
		if (reset_n)
			chk(systemClockOut, cpuClockEn, "sysclk");
		if (reset_n && rvalid && rready)
			chk({rresp, rdata}, rdQ.pop_front(), "read");
		if (reset_n && bvalid && bready)
			chk(bresp, wrQ.pop_front(), "bresp");
	end

	initial
	begin
		repeat (100000) @(posedge clock);
		fail("timeout");
		summarize;
	end

	////////////////////////////////////////////////////////////////
	initial
	begin
		reset_n = 1'b0;
		{awvalid, wvalid, arvalid, useExt} = '0;
		{bready, rready} = 2'b11;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		wstrb = '0;
		repeat (20) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		chk(pllPowered, 1'b1, "powered");
		chk(pllLocked, 1'b0, "locked");
		rd(`PCC_IDX_PLL_CONTROL, 32'h0);
		rate(1);
		wr(`PCC_IDX_PLL_CONTROL, 32'h4);
		rd(`PCC_IDX_PLL_CONTROL, 32'h0);
		wr(`PCC_IDX_PROT, 32'h1);
		for (n = 1; n <= 10; n++)
		begin
			wr(`PCC_IDX_WATCHDOG_CONTROL, 32'h68);
			wr(`PCC_IDX_PLL_CONTROL, n);
			@(posedge clock);
			chk(pllLocked, 1'b0, "bypass while locking");
			t = 0;
			while (pllLocked !== 1'b1 && t < 5000)
			begin
				@(posedge clock);
				t++;
			end
			n_tests++;
			if (t < (LOCK - 2) * ODIV || t > (LOCK + 2) * ODIV)
				fail("lock time");
			if (t >= 5000)
				summarize;
			rd(`PCC_IDX_PLL_CONTROL, n);
			rate(n);
		end
		wr(`PCC_IDX_PLL_CONTROL, 32'hb + ($unsigned($random(seed)) % 5));
		repeat (600) @(posedge clock);
		chk(pllLocked, 1'b0, "reserved ratio");
		rate(1);
		wr(`PCC_IDX_PLL_CONTROL, 32'h0);
		rate(1);
		wr(`PCC_IDX_PLL_STATUS, 32'h2);
		rate(2);
		wr(`PCC_IDX_PLL_STATUS, 32'ha);
		@(posedge clock);
		chk(pllPowered, 1'b0, "power off");
		rate(2);
		wr(`PCC_IDX_PLL_STATUS, 32'h0);
		@(posedge clock);
		chk(pllPowered, 1'b1, "bypass powered");
		rate(1);
		wr(`PCC_IDX_CLOCK_OUT_PIN_CONTROL_STATUS, 32'h1);
		useExt <= 1'b1;
		rate(1);
		d = $random(seed);
		wr(`PCC_IDX_HSPRE, d);
		rd(`PCC_IDX_HSPRE, {16'h0, d[15:0]});
		wr(16'h7012, d, `PCC_RESP_SLVERR);
		rd(16'h7012, 32'h0, `PCC_RESP_SLVERR);
		wr(`PCC_IDX_CLOCK_OUT_PIN_CONTROL_STATUS, 32'h0);
		useExt <= 1'b0;
		wr(`PCC_IDX_PLL_CONTROL, 32'h6);
		repeat (500) @(posedge clock);
		reset_n <= 1'b0;
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		chk(pllLocked, 1'b0, "reset bypass");
		rd(`PCC_IDX_PLL_CONTROL, 32'h0);
		rd(`PCC_IDX_PROT, 32'h0);
		rate(1);
		summarize;
	end
endmodule
